/* inc/mtx_pkg.sv */
// Constants and types for the transmit pin and strap block
package mtx_pkg;
  localparam logic [4:0] REG_BASIC_CTRL  = 5'h00;
  localparam logic [4:0] REG_CTRL2       = 5'h16;
  localparam logic [4:0] REG_STRAP_STAT  = 5'h1B;
  localparam logic [4:0] REG_PHY_CTRL2   = 5'h1F;
  localparam int         BIT_ANEG_EN     = 12;
  localparam int         BIT_TXC_FIX     = 15;
  localparam int         LAMP_MODE_LSB   = 4;
  localparam int         BIT_OVERFLOW    = 4;
  localparam int         BIT_IRQ_EN      = 8;
  localparam logic [15:0] BASIC_CTRL_RST = 16'h1000;
  localparam logic [15:0] CTRL2_RST      = 16'h0000;
  localparam logic [15:0] PHY_CTRL2_RST  = 16'h0000;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         TXC_PERIOD_NS   = 200;
  localparam int         TXC_DIV         = TXC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] TXC_HALF        = 3'(TXC_DIV / 2);
  localparam logic [2:0] TXC_LAST        = 3'(TXC_DIV - 1);
  // Two cycles of synchroniser delay plus margin after the rising edge
  localparam logic [2:0] TXC_SAMPLE      = 3'h6;
  localparam int         BLINK_NS        = 50_000_000;
  localparam int         BLINK_CYCLES    = BLINK_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    LM_LINK_ACT = 2'b00,
    LM_LINK     = 2'b01,
    LM_RSVD_A   = 2'b10,
    LM_RSVD_B   = 2'b11
  } mtx_lamp_mode_t;
endpackage

/* hdl/mtx_sync.sv */
// Two-flop synchroniser for pin levels
module mtx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // No reset so strap levels are valid at the release edge
  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    sync_reg <= meta_reg;
  end

  assign q_out = sync_reg;
endmodule

/* hdl/mtx_buf2.sv */
// Two-entry valid/ready buffer
module mtx_buf2 #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         s_valid_in,
  output logic              s_ready_out,
  input  wire logic [W-1:0] s_data_in,
  output logic              m_valid_out,
  input  wire logic         m_ready_in,
  output logic      [W-1:0] m_data_out
);
  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic [1:0]   count_reg;
  logic [1:0]   count_next;
  wire          push = s_valid_in && s_ready_out;
  wire          pop  = m_valid_out && m_ready_in;

  assign s_ready_out = (count_reg != 2'h2);
  assign m_valid_out = (count_reg != 2'h0);
  assign m_data_out  = head_reg;
  assign count_next  = count_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_reg <= 2'h0;
      head_reg  <= '0;
      tail_reg  <= '0;
    end else begin
      count_reg <= count_next;
      if (pop) begin
        head_reg <= (count_reg == 2'h2) ? tail_reg : s_data_in;
      end else if (push && count_reg == 2'h0) begin
        head_reg <= s_data_in;
      end
      if (push && (count_reg - {1'b0, pop}) == 2'h1) begin
        tail_reg <= s_data_in;
      end
    end
  end
endmodule

/* hdl/mtx_top.sv */
// Transmit pins, straps, interrupt pin and link lamp of the transceiver
//
// Strobed register access and the address map are this design's own decisions.
module mtx_top
  import mtx_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_CYCLES
) (
  input  wire logic       CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic [4:0] REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic      [15:0] REG_RDATA_OUT,
  input  wire logic       TXC_IN,
  output logic            TXC_OUT,
  output logic            TXC_OE_OUT,
  input  wire logic       TXEN_IN,
  input  wire logic [3:0] TXD_IN,
  input  wire logic       COL_IN,
  output logic            COL_OUT,
  output logic            COL_OE_OUT,
  input  wire logic       CRS_IN,
  output logic            CRS_OUT,
  output logic            CRS_OE_OUT,
  input  wire logic       IRQ_OUT_PIN_IN,
  output logic            IRQ_OUT_PIN_OUT,
  output logic            IRQ_OUT_PIN_OE_OUT,
  input  wire logic       LINK_ACTIVITY_LAMP_IN,
  output logic            LINK_ACTIVITY_LAMP_OUT,
  output logic            LINK_ACTIVITY_LAMP_OE_OUT,
  input  wire logic       LINK_UP_IN,
  input  wire logic       RX_ACTIVE_IN,
  input  wire logic       CARRIER_IN,
  input  wire logic       IRQ_EVENT_IN,
  output logic      [3:0] TX_NIBBLE_OUT,
  output logic            TX_VALID_OUT,
  input  wire logic       TX_READY_IN,
  output logic            AUTONEG_EN_OUT,
  output logic      [1:0] MODE_STRAP_OUT,
  output logic            TEST_MODE_OUT
);
  logic [2:0]  txc_cnt_reg;
  logic        txc_reg;
  logic        rst_d_reg;
  logic        run_reg;
  logic [15:0] basic_ctrl_reg;
  logic [15:0] ctrl2_reg;
  logic [15:0] phy_ctrl2_reg;
  logic        irq_en_reg;
  logic        overflow_reg;
  logic [1:0]  mode_strap_reg;
  logic        test_mode_n_reg;
  logic        txc_strap_reg;
  logic [15:0] rdata_reg;
  logic        col_reg;
  logic        crs_reg;
  logic        lamp_reg;
  logic        blink_reg;
  logic [31:0] blink_cnt_reg;
  logic [8:0]  pins_s;
  wire         txc_pin_s;

  mtx_sync #(.W(9)) u_sync (
    .clk_in (CLK_IN),
    .d_in   ({TXEN_IN, TXD_IN, COL_IN, CRS_IN, IRQ_OUT_PIN_IN, LINK_ACTIVITY_LAMP_IN}),
    .q_out  (pins_s)
  );
  mtx_sync #(.W(1)) u_sync_txc (
    .clk_in (CLK_IN),
    .d_in   (TXC_IN),
    .q_out  (txc_pin_s)
  );

  wire        txen_s      = pins_s[8];
  wire [3:0]  txd_s       = pins_s[7:4];
  wire        col_s       = pins_s[3];
  wire        crs_s       = pins_s[2];
  wire        irq_s       = pins_s[1];
  wire        lamp_s      = pins_s[0];
  wire        release_ev  = rst_d_reg && !SRST_IN;
  wire        sample_ev   = run_reg && (txc_cnt_reg == TXC_SAMPLE);
  wire        push        = sample_ev && txen_s;
  wire        buf_ready;
  wire        txc_allowed = !txc_strap_reg || ctrl2_reg[BIT_TXC_FIX];
  wire        activity    = txen_s || RX_ACTIVE_IN;
  wire        blink_wrap  = (blink_cnt_reg == 32'(BLINK_CYC - 1));
  wire        wr_stat     = REG_WR_IN && REG_ADDR_IN == REG_STRAP_STAT;
  wire        ovf_clear   = wr_stat && REG_WDATA_IN[BIT_OVERFLOW];
  wire        ovf_set     = push && !buf_ready;
  mtx_lamp_mode_t lamp_mode;
  assign lamp_mode = mtx_lamp_mode_t'(phy_ctrl2_reg[LAMP_MODE_LSB +: 2]);
  wire [15:0] stat_word   = {7'h00, irq_en_reg, 3'h0, overflow_reg, txc_strap_reg,
                             test_mode_n_reg, mode_strap_reg};
  wire [15:0] rd_mux      = (REG_ADDR_IN == REG_BASIC_CTRL) ? basic_ctrl_reg :
                            (REG_ADDR_IN == REG_CTRL2)      ? ctrl2_reg :
                            (REG_ADDR_IN == REG_PHY_CTRL2)  ? phy_ctrl2_reg :
                            (REG_ADDR_IN == REG_STRAP_STAT) ? stat_word : 16'h0000;

  // Only sampled nibbles with enable high enter the buffer
  mtx_buf2 #(.W(4)) u_buf (
    .clk_in      (CLK_IN),
    .srst_in     (SRST_IN),
    .s_valid_in  (push),
    .s_ready_out (buf_ready),
    .s_data_in   (txd_s),
    .m_valid_out (TX_VALID_OUT),
    .m_ready_in  (TX_READY_IN),
    .m_data_out  (TX_NIBBLE_OUT)
  );

  // Clock divider: the block makes the transmit clock itself
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || !run_reg) begin
      // Parked on the last phase so the first high phase after release is full length
      txc_cnt_reg <= TXC_LAST;
      txc_reg     <= 1'b0;
    end else begin
      txc_cnt_reg <= (txc_cnt_reg == TXC_LAST) ? 3'h0 : txc_cnt_reg + 3'h1;
      txc_reg     <= (txc_cnt_reg == TXC_LAST) || (txc_cnt_reg < TXC_HALF - 3'h1);
    end
  end

  // Strap capture on the first cycle after reset is released
  always_ff @(posedge CLK_IN) begin
    rst_d_reg <= SRST_IN;
    if (SRST_IN) begin
      run_reg         <= 1'b0;
      mode_strap_reg  <= 2'h0;
      test_mode_n_reg <= 1'b1;
      txc_strap_reg   <= 1'b0;
    end else if (release_ev) begin
      run_reg         <= 1'b1;
      mode_strap_reg  <= {crs_s, col_s};
      test_mode_n_reg <= irq_s;
      txc_strap_reg   <= txc_pin_s;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      basic_ctrl_reg <= BASIC_CTRL_RST;
      ctrl2_reg      <= CTRL2_RST;
      phy_ctrl2_reg  <= PHY_CTRL2_RST;
      irq_en_reg     <= 1'b0;
      overflow_reg   <= 1'b0;
      rdata_reg      <= 16'h0000;
    end else begin
      if (release_ev) begin
        basic_ctrl_reg[BIT_ANEG_EN] <= lamp_s;
      end else if (REG_WR_IN && REG_ADDR_IN == REG_BASIC_CTRL) begin
        basic_ctrl_reg <= REG_WDATA_IN;
      end
      if (REG_WR_IN && REG_ADDR_IN == REG_CTRL2) begin
        ctrl2_reg <= REG_WDATA_IN;
      end
      if (REG_WR_IN && REG_ADDR_IN == REG_PHY_CTRL2) begin
        phy_ctrl2_reg <= REG_WDATA_IN;
      end
      if (wr_stat) begin
        irq_en_reg <= REG_WDATA_IN[BIT_IRQ_EN];
      end
      // A lost nibble in the clearing cycle still sets the flag
      overflow_reg <= ovf_set || (overflow_reg && !ovf_clear);
      rdata_reg    <= REG_RD_IN ? rd_mux : 16'h0000;
    end
  end

  // Half duplex view: carrier from either direction, collision when both
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      col_reg <= 1'b0;
      crs_reg <= 1'b0;
    end else begin
      col_reg <= CARRIER_IN && txen_s;
      crs_reg <= CARRIER_IN || txen_s;
    end
  end

  // Blink phase runs only during activity so idle returns to link level
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || !activity) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_wrap ? 32'h0000_0000 : blink_cnt_reg + 32'h0000_0001;
      blink_reg     <= blink_reg ^ blink_wrap;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      lamp_reg <= 1'b1;
    end else begin
      unique case (lamp_mode)
        // Activity blinks around the link level, so the blink shows with or without link
        LM_LINK_ACT: lamp_reg <= !LINK_UP_IN ^ (activity && blink_reg);
        LM_LINK:     lamp_reg <= !LINK_UP_IN;
        LM_RSVD_A:   lamp_reg <= 1'b1;
        LM_RSVD_B:   lamp_reg <= 1'b1;
      endcase
    end
  end

  // Shared strap pins are released during reset so their pulls can be read
  assign REG_RDATA_OUT             = rdata_reg;
  assign TXC_OUT                   = txc_reg;
  assign TXC_OE_OUT                = run_reg && txc_allowed;
  assign COL_OUT                   = col_reg;
  assign COL_OE_OUT                = run_reg;
  assign CRS_OUT                   = crs_reg;
  assign CRS_OE_OUT                = run_reg;
  assign IRQ_OUT_PIN_OUT           = 1'b0;
  assign IRQ_OUT_PIN_OE_OUT        = run_reg && irq_en_reg && IRQ_EVENT_IN;
  assign LINK_ACTIVITY_LAMP_OUT    = lamp_reg;
  assign LINK_ACTIVITY_LAMP_OE_OUT = run_reg;
  assign AUTONEG_EN_OUT            = basic_ctrl_reg[BIT_ANEG_EN];
  assign MODE_STRAP_OUT            = mode_strap_reg;
  assign TEST_MODE_OUT             = !test_mode_n_reg;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_txc_high;
    TXC_OUT [*4];
  endsequence
  sequence s_txc_low;
    !TXC_OUT [*4];
  endsequence
  property p_txc_shape;
    run_reg && $rose(TXC_OUT) |-> s_txc_high ##1 !TXC_OUT;
  endproperty
  a_txc_shape: assert property (p_txc_shape) else $error("transmit clock high phase wrong");
  property p_txc_low;
    run_reg && $fell(TXC_OUT) |-> s_txc_low ##1 TXC_OUT;
  endproperty
  a_txc_low: assert property (p_txc_low) else $error("transmit clock low phase wrong");
  property p_ignore;
    sample_ev && !txen_s && !ovf_clear |=> $stable(overflow_reg) && ($past(TX_VALID_OUT) || !TX_VALID_OUT) &&
      (TX_VALID_OUT || !$past(TX_VALID_OUT) || $past(TX_READY_IN));
  endproperty
  a_ignore: assert property (p_ignore) else $error("nibble taken with enable low");
  property p_push;
    push && buf_ready && !TX_VALID_OUT |=> TX_VALID_OUT && TX_NIBBLE_OUT == $past(txd_s);
  endproperty
  a_push: assert property (p_push) else $error("sampled nibble not presented");
  property p_txc_oe;
    run_reg && !txc_strap_reg |-> TXC_OE_OUT;
  endproperty
  a_txc_oe: assert property (p_txc_oe) else $error("transmit clock not driven");
  property p_col;
    ##1 COL_OUT == ($past(CARRIER_IN) && $past(txen_s)) && COL_OE_OUT == run_reg;
  endproperty
  a_col: assert property (p_col) else $error("collision output wrong");
  property p_strap;
    release_ev |=> MODE_STRAP_OUT == $past({crs_s, col_s}) && TEST_MODE_OUT == !$past(irq_s);
  endproperty
  a_strap: assert property (p_strap) else $error("mode or test strap not captured");
  property p_irq;
    !IRQ_OUT_PIN_OUT && (IRQ_OUT_PIN_OE_OUT == (run_reg && irq_en_reg && IRQ_EVENT_IN));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin drives high");
  property p_aneg;
    release_ev |=> AUTONEG_EN_OUT == $past(lamp_s);
  endproperty
  a_aneg: assert property (p_aneg) else $error("autoneg strap not loaded");
  property p_lamp_link;
    lamp_mode == LM_LINK_ACT && LINK_UP_IN && !activity ##1 LINK_UP_IN && !activity
      |-> !LINK_ACTIVITY_LAMP_OUT;
  endproperty
  a_lamp_link: assert property (p_lamp_link) else $error("lamp not at link level");
  property p_lamp_rsvd;
    lamp_mode == LM_RSVD_A |=> LINK_ACTIVITY_LAMP_OUT;
  endproperty
  a_lamp_rsvd: assert property (p_lamp_rsvd) else $error("lamp mode not honoured");
  property p_blink;
    activity && blink_wrap |=> blink_reg != $past(blink_reg);
  endproperty
  a_blink: assert property (p_blink) else $error("blink phase did not toggle");
endmodule

/* tb/mtx_mac_model.sv */
// Behavioural MAC driving the transmit enable and nibble lines
module mtx_mac_model (
  input  wire logic       clk_in,
  input  wire logic       txc_in,
  input  wire logic       go_in,
  output logic            txen_out,
  output logic      [3:0] txd_out,
  output logic            sent_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic txc_d;
  initial begin
    txc_d    = 1'b0;
    txen_out = 1'b0;
    txd_out  = 4'h0;
    sent_out = 1'b0;
  end
  // Lines change just after a transmit clock rise, one nibble per period
  always @(posedge clk_in) begin
    txc_d    <= txc_in;
    sent_out <= 1'b0;
    if (txc_in && !txc_d) begin
      if (go_in) begin
        txen_out <= 1'b1;
        txd_out  <= 4'($urandom);
        sent_out <= 1'b1;
      end else begin
        // Junk on idle data lines must not reach the stream
        txen_out <= 1'b0;
        txd_out  <= ~txd_out;
      end
    end
  end
endmodule

/* tb/mtx_top_tb_top.sv */
// Self-checking bench for the transmit pin, strap and lamp block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module mtx_top_tb_top
  import mtx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, SRST = 1'b1, wr = 1'b0, rd = 1'b0, rd_dly = 1'b0, go = 1'b0, stall = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata, exp_r;
  logic LINK_UP = 1'b0, RX_ACT = 1'b0, CARRIER = 1'b0, IRQ_EV = 1'b0, TX_READY = 1'b0;
  logic s_txc = 1'b0, s_col = 1'b0, s_crs = 1'b0, s_irq = 1'b1, s_lamp = 1'b1, prev;
  logic txc_o, txc_oe, col_o, col_oe, crs_o, crs_oe, irq_o, irq_oe, lamp_o, lamp_oe;
  logic txen, sent, valid, aneg, test;
  logic [3:0] txd, nib, exp_n;
  logic [1:0] mode;
  int failures = 0, compares = 0, push_cnt = 0, tog, seed;
  logic [15:0] rd_q[$];
  logic [3:0] tx_q[$];
  // Pin levels: driver wins, otherwise the board strap or pull sets the wire
  wire txc_w  = txc_oe ? txc_o : s_txc;
  wire col_w  = col_oe ? col_o : s_col;
  wire crs_w  = crs_oe ? crs_o : s_crs;
  wire irq_w  = irq_oe ? irq_o : s_irq;
  wire lamp_w = lamp_oe ? lamp_o : s_lamp;
  always #12.5 CLK = ~CLK;
  mtx_top #(.BLINK_CYC(8)) dut_u (.CLK_IN(CLK), .SRST_IN(SRST), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TXC_IN(txc_w), .TXC_OUT(txc_o),
    .TXC_OE_OUT(txc_oe), .TXEN_IN(txen), .TXD_IN(txd), .COL_IN(col_w), .COL_OUT(col_o),
    .COL_OE_OUT(col_oe), .CRS_IN(crs_w), .CRS_OUT(crs_o), .CRS_OE_OUT(crs_oe), .IRQ_OUT_PIN_IN(irq_w),
    .IRQ_OUT_PIN_OUT(irq_o), .IRQ_OUT_PIN_OE_OUT(irq_oe), .LINK_ACTIVITY_LAMP_IN(lamp_w),
    .LINK_ACTIVITY_LAMP_OUT(lamp_o), .LINK_ACTIVITY_LAMP_OE_OUT(lamp_oe), .LINK_UP_IN(LINK_UP),
    .RX_ACTIVE_IN(RX_ACT), .CARRIER_IN(CARRIER), .IRQ_EVENT_IN(IRQ_EV), .TX_NIBBLE_OUT(nib),
    .TX_VALID_OUT(valid), .TX_READY_IN(TX_READY), .AUTONEG_EN_OUT(aneg), .MODE_STRAP_OUT(mode),
    .TEST_MODE_OUT(test));
  mtx_mac_model mac_u (.clk_in(CLK), .txc_in(txc_w), .go_in(go), .txen_out(txen), .txd_out(txd),
    .sent_out(sent));
  always @(posedge CLK) TX_READY <= stall ? 1'b0 : ($urandom_range(0, 3) != 0);
  // Result watcher: oldest note against each answer
  always @(posedge CLK) begin
    if (rd_dly) begin
      exp_r = rd_q.pop_front();
      `CHK(rdata, exp_r)
    end
    if (valid && TX_READY) begin
      exp_n = (tx_q.size() != 0) ? tx_q.pop_front() : ~nib;
      `CHK(nib, exp_n)
    end
    if (sent && push_cnt > 0) begin
      tx_q.push_back(txd);
      push_cnt--;
    end
    rd_dly <= rd;
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLK);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
    @(posedge CLK);
    addr <= a;
    rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge CLK);
    rd <= 1'b0;
  endtask
  task automatic wait_empty();
    for (int i = 0; i < 2000 && tx_q.size() != 0; i++) @(posedge CLK);
    if (tx_q.size() != 0) begin
      failures++;
      $display("Error at %0t: stream wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  initial begin
    seed = $urandom(32'h0010);
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      {s_col, s_crs, s_irq, s_lamp} <= 4'($urandom);
      s_txc <= (i == 0);
      SRST  <= 1'b1;
      cyc(6);
      SRST <= 1'b0;
      cyc(3);
      `CHK(mode, {s_crs, s_col})
      `CHK(test, !s_irq)
      `CHK(aneg, s_lamp)
      rd_reg(REG_STRAP_STAT, {12'h000, s_txc, s_irq, s_crs, s_col});
      rd_reg(REG_BASIC_CTRL, {3'h0, s_lamp, 12'h000});
      rd_reg(5'h05, 16'h0000);
      `CHK(txc_oe, !s_txc)
      if (s_txc) begin
        wr_reg(REG_CTRL2, 16'h8000);
        cyc(2);
        `CHK(txc_oe, 1'b1)
      end
      $display("Strap test %0d done", i);
    end
    for (int c = 0; c < 2; c++) begin
      CARRIER <= c[0];
      cyc(3);
      `CHK({col_oe, crs_oe, col_o, crs_o}, {3'b110, c[0]})
    end
    // Stream with random receiver stalls, collision seen while sending
    push_cnt = 1000;
    stall <= 1'b0;
    go    <= 1'b1;
    cyc(200);
    `CHK({col_o, crs_o}, 2'b11)
    go <= 1'b0;
    wait_empty();
    CARRIER <= 1'b0;
    $display("Stream test done");
    // Receiver stalls: two oldest nibbles kept, the rest dropped
    cyc(20);
    stall <= 1'b1;
    push_cnt = 2;
    go <= 1'b1;
    cyc(40);
    go <= 1'b0;
    cyc(16);
    stall <= 1'b0;
    wait_empty();
    rd_reg(REG_STRAP_STAT, {11'h000, 1'b1, s_txc, s_irq, s_crs, s_col});
    wr_reg(REG_STRAP_STAT, 16'h0010);
    rd_reg(REG_STRAP_STAT, {12'h000, s_txc, s_irq, s_crs, s_col});
    $display("Overflow test done");
    IRQ_EV <= 1'b1;
    cyc(2);
    `CHK(irq_oe, 1'b0)
    wr_reg(REG_STRAP_STAT, 16'h0100);
    cyc(2);
    `CHK({irq_oe, irq_w, irq_o}, 3'b100)
    IRQ_EV <= 1'b0;
    cyc(2);
    `CHK({irq_oe, irq_w}, {1'b0, s_irq})
    $display("Interrupt pin test done");
    for (int m = 0; m < 4; m++) begin
      wr_reg(REG_PHY_CTRL2, 16'(m) << LAMP_MODE_LSB);
      rd_reg(REG_PHY_CTRL2, 16'(m) << LAMP_MODE_LSB);
      for (int l = 0; l < 2; l++) begin
        LINK_UP <= l[0];
        RX_ACT  <= 1'b1;
        cyc(3);
        prev = lamp_o;
        tog  = 0;
        for (int k = 0; k < 64; k++) begin
          @(posedge CLK);
          if (lamp_o !== prev) tog++;
          prev = lamp_o;
        end
        // Blink only in mode zero, one toggle per eight cycles
        `CHK(1'(tog >= 6), 1'(m == 0))
        RX_ACT <= 1'b0;
        cyc(4);
        `CHK({lamp_oe, lamp_o}, {1'b1, (m >= 2) ? 1'b1 : !l[0]})
      end
    end
    $display("Lamp test done");
    stop_test();
  end
endmodule
